// file: clk_receiver_model.sv
// downstream receiver model: counts rising clock edges per channel
// assumes clock levels sampled on ref_clk
`timescale 1ns/1ns
module clk_receiver_model (
    input wire ref_clk, // sampling clock
    input wire reset, // async reset
    input wire [15:0] clkOut, // received clocks
    output logic [15:0][15:0] riseCnt, // edges seen per channel
    output logic [15:0][15:0] riseAt // cycle of last rising edge
);
    logic [15:0] prev;
    logic [15:0] cyc;
    // edge detect against the previous sample
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev <= 16'h0;
            cyc <= 16'h0;
            riseCnt <= '0;
            riseAt <= '0;
        end else begin
            prev <= clkOut;
            cyc <= cyc + 16'h1;
            for (int i = 0; i < 16; i++) begin
                if (clkOut[i] && !prev[i]) begin
                    riseCnt[i] <= riseCnt[i] + 16'h1;
                    riseAt[i] <= cyc;
                end
            end
        end
    end
endmodule

// file: out_sync_map.vh
// constants for the output channel sync and mute control block
// assumes inclusion by out_sync_mute_ctrl.v, its property module and its test bench
`ifndef OUT_SYNC_MAP_VH
`define OUT_SYNC_MAP_VH
// output format codes
`define FMT_OFF 3'h0
`define FMT_LVDS 3'h1
`define FMT_LVPECL 3'h2
`define FMT_HSDS 3'h3
`define FMT_CMOS 3'h4
`define FMT_CML 3'h5
// cmos pin modes
`define PIN_NORMAL 2'h0
`define PIN_INVERT 2'h1
`define PIN_HIZ 2'h2
`define PIN_LOW 2'h3
// pin function select code for align input
`define PIN_FUNC_ALIGN 6'h1F
// register offsets
`define REG_GLOBAL 8'h15
`define REG_LOCK 8'h16
`define REG_MUTECTL 8'h17
`define REG_POSTSYNC 8'h18
`define REG_CH_BASE 8'h20
`define REG_DLY_BASE 8'h40
// field positions in REG_GLOBAL
`define BIT_SW_ALIGN 6
`define BIT_SYNC_EN 0
`define BIT_PIN_POL 1
`endif

// file: out_sync_mute_ctrl.v
// output channel control: format, sysref divider, digital delay, auto-mute and align
// assumes one 100 MHz ref_clk shared as the post-divider clock; lock inputs and align pin async
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`include "out_sync_map.vh"

// register map, one word per address
// 0x15 global control
//     bit 0 align enable
//     bit 1 pin polarity invert
//     bit 2 align active, read only
//     bit 6 software align request
//     bits 13:8 pin function select, 31 makes the pin an align input
// 0x16 lock status, read only
//     bits 2:0 filtered analog lock
//     bits 10:8 filtered frequency lock
//     bits 18:16 filtered phase lock
//     bits 30:28 source valid per PLL
// 0x17 mute control
//     bits 2:0 mute on analog loop unlock
//     bits 10:8 mute on digital loop unlock
//     bits 18:16 mute on digital phase unlock
// 0x18 post-divider align enable, bits 2:0
// 0x20 + n channel n configuration word
// 0x40 + n channel n delay word
// unmapped writes are dropped and unmapped reads return zero
//
// points a user must know
// - lock inputs are filtered, so an unlock shorter than two cycles is not seen
// - a pin change reaches the dividers about five cycles after it appears
// - divide values 0 and 1 pass the clock straight and ignore align
// - illegal format codes behave as powered down
// - with mute disabled a channel starts at once, even on an unlocked source
// - with mute enabled a channel waits for a valid source before it starts

// Functional notes
// [RL1] three-bit format code per channel: off, LVDS, LVPECL, HSDS, CMOS, CML
// [RL2] CMOS only on channels 0 and 1, CML only on channels 4 and 6
// [RL3] sysref divider cascade on all channels except groups 2/3 and 14/15
// [RL4] static digital delay per channel; extra offset and sysref delay when sysref used
// [RL5] CMOS pins each normal, inverted, high impedance or static low
// [RL6] CML swing selectable normal or high
// [RL7] muted channel silences clock while its source is invalid
// [RL8] validity from per-PLL lock, gated by analog, frequency and phase mute bits
// [RL9] mute enable 0 never mutes
// [RL10] outputs start together glitch-free once analog lock reached; here a channel with mute disabled starts at once, even unlocked
// [RL11] sync group dividers leave reset on one common clock cycle
// [RL12] host sets all sync enables and routes members to one PLL output
// [RL13] align event from pin function 31 or software bit at register 21 bit 6
// [RL14] pin active high with polarity 0, active low with polarity 1
// [RL15] during align sync-enabled dividers held in reset, outputs low
// [RL16] on release common-PLL outputs restart phase aligned
// [RL17] channels with sync enable 0 ignore align events
// [RL18] outputs fed by a post-divider under reset are invalid during align
// [RL19] post-dividers not sync-enabled keep running during align
// [RL20] divide-by-1 dividers not gated by align
// [RL21] pair divider powers down when both its drivers are off
// [RL22] align pin synchronized before it controls divider reset
module out_sync_mute_ctrl #(
    parameter NCH = 16,
    parameter CDW = 12,
    parameter SDW = 20,
    parameter NPLL = 3
) (
    input wire ref_clk, // post-divider clock
    input wire reset, // async, active high
    input wire [7:0] regAddr, // register address
    input wire [31:0] regWdata, // write data
    input wire regWr, // write strobe
    input wire regRd, // read strobe
    output reg [31:0] regRdata, // read data, cycle after strobe
    input wire alignPin, // general-purpose pin raw level
    input wire [NPLL-1:0] analogLock, // analog loop lock per PLL
    input wire [NPLL-1:0] digitalLock, // digital frequency lock per PLL
    input wire [NPLL-1:0] phaseLock, // digital phase lock per PLL
    output reg [NCH-1:0] clkOut, // channel clock level
    output reg [NCH-1:0] pinP, // cmos P output
    output reg [NCH-1:0] pinPOe, // cmos P enable
    output reg [NCH-1:0] pinN, // cmos N output
    output reg [NCH-1:0] pinNOe, // cmos N enable
    output reg [NCH-1:0] highSwing, // cml high swing select
    output reg [NCH-1:0] chanPowered, // driver powered
    output reg [7:0] dividerPowered // divider powered per divider slot
);
    // sysref capable channel
    function hasSysref;
        input integer c;
        begin
            hasSysref = !(c == 2 || c == 3 || c == 14 || c == 15); // RL3
        end
    endfunction

    // legal format for a channel
    function [2:0] legalFmt;
        input integer c;
        input [2:0] f;
        begin
            if (f == `FMT_CMOS && c > 1)
                legalFmt = `FMT_OFF; // RL2
            else if (f == `FMT_CML && !(c == 4 || c == 6))
                legalFmt = `FMT_OFF; // RL2
            else if (f > `FMT_CML)
                legalFmt = `FMT_OFF;
            else
                legalFmt = f; // RL1
        end
    endfunction

    // global and per-PLL control
    reg syncEnable_q;
    reg pinPolarityInvert_q;
    reg softwareAlignRequest_q;
    reg [5:0] pinFunctionSelect_q;
    reg [NPLL-1:0] muteOnAnalogLoopUnlock_q;
    reg [NPLL-1:0] muteOnDigitalLoopUnlock_q;
    reg [NPLL-1:0] muteOnDigitalPhaseUnlock_q;
    reg [NPLL-1:0] postDividerSyncEnable_q;
    // per-channel control words
    reg [31:0] chCfg_q [0:NCH-1];
    reg [31:0] chDly_q [0:NCH-1];

    // loop indices, one per process so that no index has two drivers
    integer i;
    integer j;
    integer k;

    // register writes
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            syncEnable_q <= 1'b0;
            pinPolarityInvert_q <= 1'b0;
            softwareAlignRequest_q <= 1'b0;
            pinFunctionSelect_q <= 6'h00;
            muteOnAnalogLoopUnlock_q <= {NPLL{1'b1}};
            muteOnDigitalLoopUnlock_q <= {NPLL{1'b0}};
            muteOnDigitalPhaseUnlock_q <= {NPLL{1'b0}};
            postDividerSyncEnable_q <= {NPLL{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                chCfg_q[i] <= 32'h00000000;
                chDly_q[i] <= 32'h00000000;
            end
        end else if (regWr) begin
            if (regAddr == `REG_GLOBAL) begin
                syncEnable_q <= regWdata[`BIT_SYNC_EN];
                pinPolarityInvert_q <= regWdata[`BIT_PIN_POL];
                softwareAlignRequest_q <= regWdata[`BIT_SW_ALIGN]; // RL13
                pinFunctionSelect_q <= regWdata[13:8];
            end
            if (regAddr == `REG_MUTECTL) begin
                muteOnAnalogLoopUnlock_q <= regWdata[NPLL-1:0]; // RL8
                muteOnDigitalLoopUnlock_q <= regWdata[NPLL+7:8];
                muteOnDigitalPhaseUnlock_q <= regWdata[NPLL+15:16];
            end
            if (regAddr == `REG_POSTSYNC)
                postDividerSyncEnable_q <= regWdata[NPLL-1:0];
            for (i = 0; i < NCH; i = i + 1) begin
                if (regAddr == `REG_CH_BASE + i[7:0])
                    chCfg_q[i] <= regWdata;
                if (regAddr == `REG_DLY_BASE + i[7:0])
                    chDly_q[i] <= regWdata;
            end
        end
    end

    // three-stage sampling of async inputs; change accepted when stages 2 and 3 agree
    // the pin and the lock levels come from other clocks, so the first stage may
    // go metastable; only stages 2 and 3 are ever compared, never stage 1
    // a level that flips back within one cycle is never accepted
    reg [2:0] pinSync_q;
    reg pinLevel_q;
    reg [NPLL-1:0] aS1_q, aS2_q, aS3_q, dS1_q, dS2_q, dS3_q, pS1_q, pS2_q, pS3_q;
    reg [NPLL-1:0] aLk_q, dLk_q, pLk_q;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinSync_q <= 3'h0;
            pinLevel_q <= 1'b0;
            {aS1_q, aS2_q, aS3_q, aLk_q} <= {4*NPLL{1'b0}};
            {dS1_q, dS2_q, dS3_q, dLk_q} <= {4*NPLL{1'b0}};
            {pS1_q, pS2_q, pS3_q, pLk_q} <= {4*NPLL{1'b0}};
        end else begin
            pinSync_q <= {pinSync_q[1:0], alignPin}; // RL22
            if (pinSync_q[1] == pinSync_q[2])
                pinLevel_q <= pinSync_q[2];
            aS1_q <= analogLock;
            aS2_q <= aS1_q;
            aS3_q <= aS2_q;
            dS1_q <= digitalLock;
            dS2_q <= dS1_q;
            dS3_q <= dS2_q;
            pS1_q <= phaseLock;
            pS2_q <= pS1_q;
            pS3_q <= pS2_q;
            aLk_q <= (aS2_q & aS3_q) | (aLk_q & (aS2_q | aS3_q));
            dLk_q <= (dS2_q & dS3_q) | (dLk_q & (dS2_q | dS3_q));
            pLk_q <= (pS2_q & pS3_q) | (pLk_q & (pS2_q | pS3_q));
        end
    end

    // align request: pin in align function with polarity, or software bit
    // registered once so that every channel sees the same release cycle
    wire pinAssert = (pinFunctionSelect_q == `PIN_FUNC_ALIGN) &&
        (pinLevel_q ^ pinPolarityInvert_q); // RL14
    reg alignActive_q;
    always @(posedge ref_clk or posedge reset) begin
        if (reset)
            alignActive_q <= 1'b0;
        else
            alignActive_q <= syncEnable_q & (pinAssert | softwareAlignRequest_q); // RL13
    end

    // per-PLL source validity and post-divider reset
    wire [NPLL-1:0] pllValid = ~((muteOnAnalogLoopUnlock_q & ~aLk_q) |
        (muteOnDigitalLoopUnlock_q & ~dLk_q) |
        (muteOnDigitalPhaseUnlock_q & ~pLk_q)); // RL8
    wire [NPLL-1:0] postReset = {NPLL{alignActive_q}} & postDividerSyncEnable_q; // RL19

    // per-channel dividers, delay and driver
    // timing of one channel
    // - held or not running: counters reload, delays reload, output low
    // - running: the start delay counts down first, then the divider counts
    // - the divider toggles its output every divide value cycles
    // - the sysref divider steps on each falling output of the channel divider
    // - clkOut follows the internal level one cycle later
    // every channel of an align group reloads the same way while held, so all
    // of them leave the hold on one and the same edge
    // chCfg: [2:0] fmt, [3] mute en, [4] div sync en, [5] sysref sync en, [6] sysref sel,
    //        [7] high swing, [9:8] pll src, [11:10] P mode, [13:12] N mode, [27:16] cd
    // chDly: [7:0] cd delay, [15:8] sysref offset delay, [23:16] sysref delay, [31:24] sd
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            wire [2:0] fmt = legalFmt(g, chCfg_q[g][2:0]);
            wire muteEn = chCfg_q[g][3];
            wire divSync = chCfg_q[g][4];
            wire srSync = chCfg_q[g][5] & divSync;
            wire srSel = chCfg_q[g][6] & hasSysref(g); // RL3
            wire [1:0] src = (chCfg_q[g][9:8] < NPLL) ? chCfg_q[g][9:8] : 2'h0;
            wire [CDW-1:0] cdVal = chCfg_q[g][CDW+15:16];
            wire [SDW-1:0] sdVal = {{(SDW-8){1'b0}}, chDly_q[g][31:24]};
            wire bypass = (cdVal <= {{(CDW-1){1'b0}}, 1'b1}); // RL20
            wire holdDiv = alignActive_q & divSync & !bypass; // RL15 RL17
            wire srcValid = pllValid[src] & !postReset[src]; // RL18
            wire mute = muteEn & !srcValid; // RL7 RL9
            reg [CDW-1:0] cdCnt_q;
            reg [7:0] dlyCnt_q;
            reg cdOut_q;
            reg [SDW-1:0] sdCnt_q;
            reg sdOut_q;
            reg [7:0] srDly_q;
            reg running_q;
            wire cdTick = (dlyCnt_q == 8'h00) && (bypass || cdCnt_q == cdVal - 1'b1);
            // channel divider with static start delay, held by align
            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    cdCnt_q <= {CDW{1'b0}};
                    dlyCnt_q <= 8'h00;
                    cdOut_q <= 1'b0;
                    sdCnt_q <= {SDW{1'b0}};
                    sdOut_q <= 1'b0;
                    srDly_q <= 8'h00;
                    running_q <= 1'b0;
                end else if (holdDiv || postReset[src] || !running_q) begin
                    // every member reloads identically so release is one common cycle
                    cdCnt_q <= {CDW{1'b0}}; // RL11 RL16
                    dlyCnt_q <= chDly_q[g][7:0]; // RL4
                    cdOut_q <= 1'b0;
                    sdCnt_q <= {SDW{1'b0}};
                    sdOut_q <= 1'b0;
                    srDly_q <= chDly_q[g][15:8] + chDly_q[g][23:16]; // RL4
                    // with mute off the channel starts at once, even unlocked
                    running_q <= (fmt != `FMT_OFF) & (!muteEn | pllValid[src]) &
                        !holdDiv; // RL10 RL9
                end else begin
                    if (dlyCnt_q != 8'h00)
                        dlyCnt_q <= dlyCnt_q - 8'h01;
                    else if (bypass)
                        cdOut_q <= ~cdOut_q;
                    else if (cdTick) begin
                        cdCnt_q <= {CDW{1'b0}};
                        cdOut_q <= ~cdOut_q;
                    end else
                        cdCnt_q <= cdCnt_q + 1'b1;
                    // sysref divider cascaded after the channel divider
                    if (cdTick && cdOut_q && srDly_q != 8'h00)
                        srDly_q <= srDly_q - 8'h01;
                    else if (cdTick && cdOut_q) begin
                        if (sdCnt_q >= sdVal) begin
                            sdCnt_q <= {SDW{1'b0}};
                            sdOut_q <= ~sdOut_q;
                        end else
                            sdCnt_q <= sdCnt_q + 1'b1;
                    end
                    if (fmt == `FMT_OFF)
                        running_q <= 1'b0;
                end
            end
            wire level = (srSel ? sdOut_q : cdOut_q) & !mute & !(srSync & holdDiv);
            // driver state from format and mode
            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    clkOut[g] <= 1'b0;
                    pinP[g] <= 1'b0;
                    pinPOe[g] <= 1'b0;
                    pinN[g] <= 1'b0;
                    pinNOe[g] <= 1'b0;
                    highSwing[g] <= 1'b0;
                    chanPowered[g] <= 1'b0;
                end else begin
                    clkOut[g] <= level & (fmt != `FMT_OFF); // RL15
                    chanPowered[g] <= (fmt != `FMT_OFF); // RL1
                    highSwing[g] <= (fmt == `FMT_CML) & chCfg_q[g][7]; // RL6
                    pinPOe[g] <= (fmt == `FMT_CMOS) && chCfg_q[g][11:10] != `PIN_HIZ; // RL5
                    pinNOe[g] <= (fmt == `FMT_CMOS) && chCfg_q[g][13:12] != `PIN_HIZ;
                    pinP[g] <= (chCfg_q[g][11:10] == `PIN_NORMAL) ? level :
                        (chCfg_q[g][11:10] == `PIN_INVERT) ? (!mute & ~level) : 1'b0;
                    pinN[g] <= (chCfg_q[g][13:12] == `PIN_NORMAL) ? level :
                        (chCfg_q[g][13:12] == `PIN_INVERT) ? (!mute & ~level) : 1'b0;
                end
            end
        end
    endgenerate

    // divider power: slots 0/1 single, 2..7 pairs 2/3 .. 12/13
    // a pair divider stays powered while either of its drivers is on
    always @(posedge ref_clk or posedge reset) begin
        if (reset)
            dividerPowered <= 8'h00;
        else begin
            dividerPowered[0] <= chanPowered[0];
            dividerPowered[1] <= chanPowered[1];
            for (j = 2; j < 8; j = j + 1)
                dividerPowered[j] <= chanPowered[2*j-2] | chanPowered[2*j-1]; // RL21
        end
    end

    // read data, one cycle after strobe; unmapped reads zero
    // the word stands for one cycle only and then returns to zero
    always @(posedge ref_clk or posedge reset) begin
        if (reset)
            regRdata <= 32'h00000000;
        else if (regRd) begin
            regRdata <= 32'h00000000;
            if (regAddr == `REG_GLOBAL)
                regRdata <= {18'h0, pinFunctionSelect_q, 1'b0, softwareAlignRequest_q,
                    3'h0, alignActive_q, pinPolarityInvert_q, syncEnable_q};
            if (regAddr == `REG_LOCK)
                regRdata <= {8'h0, 5'h0, pLk_q, 5'h0, dLk_q, 5'h0, aLk_q} |
                    {1'b0, pllValid, 28'h0};
            if (regAddr == `REG_MUTECTL)
                regRdata <= {8'h0, 5'h0, muteOnDigitalPhaseUnlock_q, 5'h0,
                    muteOnDigitalLoopUnlock_q, 5'h0, muteOnAnalogLoopUnlock_q};
            if (regAddr == `REG_POSTSYNC)
                regRdata <= {29'h0, postDividerSyncEnable_q};
            for (k = 0; k < NCH; k = k + 1) begin
                if (regAddr == `REG_CH_BASE + k[7:0])
                    regRdata <= chCfg_q[k];
                if (regAddr == `REG_DLY_BASE + k[7:0])
                    regRdata <= chDly_q[k];
            end
        end else
            regRdata <= 32'h00000000;
    end
endmodule

// file: out_sync_mute_ctrl_properties.sv
// port assertions for the output sync and mute control block
// assumes sixteen channels and the register map of out_sync_map.vh
`timescale 1ns/1ns
`include "out_sync_map.vh"
module out_sync_mute_ctrl_properties #(
    parameter NCH = 16
) (
    input wire ref_clk, // clock
    input wire reset, // async reset
    input wire [7:0] regAddr, // address
    input wire [31:0] regWdata, // write data
    input wire regWr, // write strobe
    input wire regRd, // read strobe
    input wire [31:0] regRdata, // read data
    input wire [NCH-1:0] clkOut, // channel clocks
    input wire [NCH-1:0] pinPOe, // p enable
    input wire [NCH-1:0] pinNOe, // n enable
    input wire [NCH-1:0] highSwing, // cml swing
    input wire [NCH-1:0] chanPowered, // driver power
    input wire [7:0] dividerPowered // divider power
);
    reg swAlign_q;
    reg chHold_q;
    wire [15:0] cp = chanPowered;
    wire [7:0] divNeed = {cp[13] | cp[12], cp[11] | cp[10], cp[9] | cp[8], cp[7] | cp[6],
        cp[5] | cp[4], cp[3] | cp[2], cp[1], cp[0]};
    // shadow of software align and channel 0 hold settings
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            swAlign_q <= 1'b0;
            chHold_q <= 1'b0;
        end else if (regWr && regAddr == `REG_GLOBAL) begin
            swAlign_q <= regWdata[0] & regWdata[6];
        end else if (regWr && regAddr == `REG_CH_BASE) begin
            chHold_q <= regWdata[4] & (regWdata[27:16] > 12'h1);
        end
    end
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_cmos_pins_only: assert property (((pinPOe | pinNOe) & ~16'h0003) == 16'h0)
        else $error("cmos enable outside channels 0 and 1");
    a_cml_swing_only: assert property ((highSwing & ~16'h0050) == 16'h0)
        else $error("high swing outside channels 4 and 6");
    a_oe_needs_power: assert property (((pinPOe | pinNOe) & ~chanPowered) == 16'h0)
        else $error("pin driven on a powered-down channel");
    a_off_stays_low: assert property ((clkOut & ~chanPowered & ~$past(chanPowered)) == 16'h0)
        else $error("clock on a powered-down channel");
    a_pair_div_power: assert property (dividerPowered[7:2] == $past(divNeed[7:2]))
        else $error("pair divider power wrong");
    a_solo_div_power: assert property (dividerPowered[1:0] == $past(divNeed[1:0]))
        else $error("single divider power wrong");
    a_rdata_one_cycle: assert property (regRdata != 32'h0 |-> $past(regRd))
        else $error("read data outside its cycle");
    a_sw_hold_low: assert property (swAlign_q && chHold_q && $past(swAlign_q && chHold_q, 3)
        |-> !clkOut[0])
        else $error("held channel 0 toggles");
endmodule
bind out_sync_mute_ctrl out_sync_mute_ctrl_properties #(.NCH(NCH)) i_props (.ref_clk(ref_clk),
    .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .clkOut(clkOut), .pinPOe(pinPOe), .pinNOe(pinNOe),
    .highSwing(highSwing), .chanPowered(chanPowered), .dividerPowered(dividerPowered));

// file: out_sync_mute_ctrl_test.sv
// self-checking bench for the output sync and mute control block
// assumes the receiver model and the bound port checker
`timescale 1ns/1ns
`include "out_sync_map.vh"
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module out_sync_mute_ctrl_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic alignPin = 1'b0;
    logic [2:0] analogLock = 3'h7;
    logic [2:0] digitalLock = 3'h7;
    logic [2:0] phaseLock = 3'h7;
    wire [31:0] regRdata;
    wire [15:0] clkOut, pinP, pinPOe, pinN, pinNOe, highSwing, chanPowered;
    wire [7:0] dividerPowered;
    wire [15:0][15:0] riseCnt, riseAt;
    int error_cnt = 0;
    int checked = 0;
    logic [31:0] rdv;
    logic [31:0] rnd;
    logic pol;
    out_sync_mute_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .alignPin(alignPin), .analogLock(analogLock), .digitalLock(digitalLock),
        .phaseLock(phaseLock), .clkOut(clkOut), .pinP(pinP), .pinPOe(pinPOe), .pinN(pinN),
        .pinNOe(pinNOe), .highSwing(highSwing), .chanPowered(chanPowered),
        .dividerPowered(dividerPowered));
    clk_receiver_model i_rx (.ref_clk(ref_clk), .reset(reset), .clkOut(clkOut),
        .riseCnt(riseCnt), .riseAt(riseAt));
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // expected legality of a format on a channel
    function automatic logic fmtOk(input int ch, input int f);
        return (f >= 1 && f <= 3) || (f == 4 && ch < 2) || (f == 5 && (ch == 4 || ch == 6));
    endfunction
    // channel configuration word
    function automatic logic [31:0] cfg(input int f, mu, ds, src, hs, pm, nm, dv);
        return {4'h0, dv[11:0], 2'h0, nm[1:0], pm[1:0], src[1:0], hs[0], 2'h0, ds[0], mu[0], f[2:0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        d = regRdata;
    endtask
    // compares whether a channel toggled during a window
    task automatic active(input int ch, input logic ex);
        logic [15:0] c;
        c = riseCnt[ch];
        cyc(16);
        `CHECK("toggling", ex, riseCnt[ch] != c)
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        cyc(90000);
        error_cnt++;
        complete_run;
    end
    // main sequence
    initial begin
        void'($urandom(32'h3bebd16e));
        cyc(3);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rnd = $urandom;
            wr(`REG_DLY_BASE + i, rnd);
            rd(`REG_DLY_BASE + i, rdv);
            `CHECK("delay reg", rnd, rdv)
            wr(`REG_DLY_BASE + i, 32'h0);
        end
        rd(8'h7F, rdv);
        `CHECK("unmapped", 32'h0, rdv)
        for (int ch = 0; ch < 8; ch++) begin
            for (int f = 0; f < 8; f++) begin
                wr(`REG_CH_BASE + ch, cfg(f, 0, 0, 0, 1, 0, 0, 2));
                cyc(3);
                `CHECK("power", fmtOk(ch, f), chanPowered[ch])
                `CHECK("cmos enable", fmtOk(ch, f) && f == 4, pinPOe[ch])
                `CHECK("swing", fmtOk(ch, f) && f == 5, highSwing[ch])
            end
        end
        for (int m = 0; m < 4; m++) begin
            wr(`REG_CH_BASE, cfg(`FMT_CMOS, 0, 0, 0, 0, m, `PIN_INVERT, 1));
            cyc(4);
            `CHECK("p enable", m != 2, pinPOe[0])
            if (m != 2) `CHECK("p level", m == 3 ? 1'b0 : (m == 1) ~^ pinN[0], pinP[0])
        end
        wr(`REG_CH_BASE + 2, cfg(`FMT_LVDS, 0, 0, 0, 0, 0, 0, 2));
        analogLock <= 3'h6;
        cyc(8);
        active(2, 1'b1);
        wr(`REG_CH_BASE + 2, cfg(`FMT_LVDS, 1, 0, 0, 0, 0, 0, 2));
        cyc(8);
        active(2, 1'b0);
        analogLock <= 3'h7;
        cyc(8);
        active(2, 1'b1);
        wr(`REG_MUTECTL, 32'h00000100);
        digitalLock <= 3'h6;
        cyc(8);
        active(2, 1'b0);
        digitalLock <= 3'h7;
        wr(`REG_CH_BASE, cfg(`FMT_LVDS, 0, 1, 0, 0, 0, 0, 3));
        cyc(1);
        wr(`REG_CH_BASE + 1, cfg(`FMT_LVDS, 0, 1, 0, 0, 0, 0, 3));
        wr(`REG_CH_BASE + 3, cfg(`FMT_LVDS, 0, 1, 1, 0, 0, 0, 1));
        wr(`REG_CH_BASE + 4, cfg(`FMT_LVDS, 1, 0, 1, 0, 0, 0, 2));
        wr(`REG_POSTSYNC, 32'h1);
        wr(`REG_GLOBAL, 32'h41);
        cyc(8);
        active(0, 1'b0);
        active(1, 1'b0);
        active(2, 1'b0);
        active(3, 1'b1);
        active(4, 1'b1);
        wr(`REG_GLOBAL, 32'h1);
        cyc(20);
        `CHECK("aligned", riseAt[0], riseAt[1])
        rnd = {16'h0, riseCnt[0]};
        cyc(60);
        `CHECK("period", rnd[15:0] + 16'hA, riseCnt[0])
        pol = $urandom;
        alignPin <= pol;
        wr(`REG_GLOBAL, {30'h7C0, pol, 1'b1});
        cyc(8);
        active(0, 1'b1);
        alignPin <= ~pol;
        cyc(8);
        active(0, 1'b0);
        active(4, 1'b1);
        alignPin <= pol;
        cyc(20);
        `CHECK("pin aligned", riseAt[0], riseAt[1])
        wr(`REG_GLOBAL, {30'h780, pol, 1'b1});
        alignPin <= ~pol;
        cyc(8);
        active(0, 1'b1);
        complete_run;
    end
endmodule
